//--- udv_id_fields.sv
// udid version/revision byte and interface word with byte read port
`include "udv_params.svh"

// Behaviour
// - the top two bits of the version/revision byte always read zero.
// - the identifier-format version field always reads 001b and never a reserved code.
// - the low three bits of the version byte carry the vendor-chosen silicon revision.
// - the low nibble of the interface word reads 0100b for SMBus version 2.0.
// - the interface word never reports version code 0000b or 0001b.
// - interface bits 15 to 7 carry no meaning of this device's own.
// - interface bit 6 is set only when IPMI access is supported.
// - interface bit 5 is set only when ASF access is supported.
// - interface bit 4 is set when vendor-specific subsystem access is offered.
// - both fields are presented as part of the unique device identifier.
module udv_id_fields #(
    parameter logic [2:0] SIL_REV = `UDV_SIL_REV_DEF
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic strap_ipmi_i,
    input wire logic strap_asf_i,
    input wire logic strap_oem_i,
    input wire udv_pkg::udv_rd_req_s rd_req_i,
    output udv_pkg::udv_ver_s version_revision_byte_o,
    output udv_pkg::udv_if_s interface_capability_word_o,
    output logic fields_valid_o,
    output udv_pkg::udv_rd_rsp_s rd_rsp_o
);

    udv_pkg::udv_strap_s strap_in;
    udv_pkg::udv_strap_s strap_frozen;
    logic locked;

    udv_pkg::udv_ver_s ver;
    udv_pkg::udv_ver_s next_ver;
    udv_pkg::udv_if_s iface;
    udv_pkg::udv_if_s next_iface;
    logic valid;
    logic next_valid;
    udv_pkg::udv_rd_rsp_s rsp;
    udv_pkg::udv_rd_rsp_s next_rsp;

    function automatic udv_pkg::udv_ver_s make_ver(input logic [2:0] rev);
        udv_pkg::udv_ver_s v;
        v.rsvd = `UDV_VER_RSVD;
        v.fmt_ver = `UDV_FMT_VER;
        v.sil_rev = rev;
        return v;
    endfunction : make_ver

    function automatic udv_pkg::udv_if_s make_if(input udv_pkg::udv_strap_s s);
        udv_pkg::udv_if_s w;
        w.rsvd = `UDV_IF_RSVD;
        w.ipmi = s.ipmi;
        w.asf = s.asf;
        w.oem = s.oem;
        w.smb_ver = `UDV_SMB_VER;
        return w;
    endfunction : make_if

    assign strap_in.ipmi = strap_ipmi_i;
    assign strap_in.asf = strap_asf_i;
    assign strap_in.oem = strap_oem_i;

    udv_strap_cap u_strap_cap (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .strap_i(strap_in),
        .strap_o(strap_frozen),
        .locked_o(locked)
    );

    // fields: fixed parts from reset, flags once the straps are frozen
    always_comb begin
        next_ver = make_ver(SIL_REV);
        next_iface = make_if(strap_frozen);
        if (!locked) begin
            next_iface.ipmi = 1'b0;
            next_iface.asf = 1'b0;
            next_iface.oem = 1'b0;
        end
        next_valid = locked;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ver <= {`UDV_VER_RSVD, `UDV_FMT_VER, SIL_REV};
            iface <= {`UDV_IF_RSVD, 3'h0, `UDV_SMB_VER};
            valid <= 1'b0;
        end else begin
            ver <= next_ver;
            iface <= next_iface;
            valid <= next_valid;
        end
    end

    // udid byte read port: index counts bytes from the msb end
    always_comb begin
        next_rsp = '0;
        next_rsp.ack = rd_req_i.req;
        if (rd_req_i.req) begin
            case (rd_req_i.idx)
                `UDV_IDX_VER: begin
                    next_rsp.hit = 1'b1;
                    next_rsp.data = ver;
                end
                `UDV_IDX_IF_HI: begin
                    next_rsp.hit = 1'b1;
                    next_rsp.data = iface[15:8];
                end
                `UDV_IDX_IF_LO: begin
                    next_rsp.hit = 1'b1;
                    next_rsp.data = iface[7:0];
                end
                default: begin
                    next_rsp.hit = 1'b0;
                    next_rsp.data = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

    assign version_revision_byte_o = ver;
    assign interface_capability_word_o = iface;
    assign fields_valid_o = valid;
    assign rd_rsp_o = rsp;

    a_ver_rsvd_zero: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        version_revision_byte_o[7:6] == 2'h0)
        else $error("version reserved bits not zero");

    a_fmt_ver_one: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        version_revision_byte_o[5:3] == 3'h1)
        else $error("format version not 001b");

    a_sil_rev_value: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        version_revision_byte_o[2:0] == SIL_REV)
        else $error("silicon revision mismatch");

    a_smb_ver_two: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        interface_capability_word_o[3:0] == 4'h4)
        else $error("smbus version not 0100b");

    a_no_old_ver: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        interface_capability_word_o[3:0] != `UDV_SMB_VER_10 &&
        interface_capability_word_o[3:0] != `UDV_SMB_VER_11)
        else $error("legacy smbus version reported");

    a_if_rsvd_zero: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        interface_capability_word_o[15:7] == 9'h000)
        else $error("interface reserved bits not zero");

    a_ipmi_flag: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        fields_valid_o |-> interface_capability_word_o[6] == strap_frozen.ipmi)
        else $error("ipmi flag does not match support");

    a_asf_flag: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        fields_valid_o |-> interface_capability_word_o[5] == strap_frozen.asf)
        else $error("asf flag does not match support");

    a_oem_flag: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        fields_valid_o |-> interface_capability_word_o[4] == strap_frozen.oem)
        else $error("oem flag does not match support");

    // flags at freeze are the pin levels seen at the first edge after reset
    a_flags_from_pins: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        $rose(fields_valid_o) |->
        interface_capability_word_o[6:4] == $past({strap_ipmi_i, strap_asf_i, strap_oem_i}, 4))
        else $error("flags do not follow support pins");

    a_flags_idle_early: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        !fields_valid_o |-> interface_capability_word_o[6:4] == 3'h0)
        else $error("flags set before straps frozen");

    a_rd_ver_byte: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        rd_req_i.req && rd_req_i.idx == 4'h1 |=>
        rd_rsp_o.ack && rd_rsp_o.hit && rd_rsp_o.data == $past(version_revision_byte_o))
        else $error("version byte read wrong");

    a_rd_if_word: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        rd_req_i.req && rd_req_i.idx == 4'h6 ##1 rd_req_i.req && rd_req_i.idx == 4'h7 |=>
        rd_rsp_o.data == $past(interface_capability_word_o[7:0]) &&
        $past(rd_rsp_o.data) == $past(interface_capability_word_o[15:8], 2))
        else $error("interface word read wrong");

    a_rd_ack_pulse: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        rd_req_i.req |=> rd_rsp_o.ack)
        else $error("read request not acknowledged");

    a_rd_other_idx: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        rd_req_i.req && rd_req_i.idx != 4'h1 && rd_req_i.idx != 4'h6 && rd_req_i.idx != 4'h7
        |=> rd_rsp_o.ack && !rd_rsp_o.hit && rd_rsp_o.data == 8'h00)
        else $error("foreign byte index answered with data");

    a_rd_miss_zero: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        !rd_req_i.req |=> !rd_rsp_o.ack && !rd_rsp_o.hit && rd_rsp_o.data == 8'h00)
        else $error("read response without request");

    a_fields_stable: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        fields_valid_o |=> $stable(interface_capability_word_o) &&
        $stable(version_revision_byte_o))
        else $error("fields changed after freeze");

endmodule : udv_id_fields

//--- udv_params.svh
// constants for the udid version and interface fields
`ifndef UDV_PARAMS_SVH
`define UDV_PARAMS_SVH

`define UDV_VER_RSVD 2'h0
`define UDV_FMT_VER 3'h1
`define UDV_SMB_VER 4'h4
`define UDV_SMB_VER_10 4'h0
`define UDV_SMB_VER_11 4'h1
`define UDV_IF_RSVD 9'h000
`define UDV_SIL_REV_DEF 3'h0
`define UDV_IDX_VER 4'h1
`define UDV_IDX_IF_HI 4'h6
`define UDV_IDX_IF_LO 4'h7
`define UDV_SETTLE_CYC 2'h2
`define UDV_LOCK_MAX 4

`endif

//--- udv_pkg.sv
// types for the udid version and interface fields
package udv_pkg;

    typedef struct packed {
        logic [1:0] rsvd;
        logic [2:0] fmt_ver;
        logic [2:0] sil_rev;
    } udv_ver_s;

    typedef struct packed {
        logic [8:0] rsvd;
        logic ipmi;
        logic asf;
        logic oem;
        logic [3:0] smb_ver;
    } udv_if_s;

    typedef struct packed {
        logic ipmi;
        logic asf;
        logic oem;
    } udv_strap_s;

    typedef struct packed {
        logic req;
        logic [3:0] idx;
    } udv_rd_req_s;

    typedef struct packed {
        logic ack;
        logic hit;
        logic [7:0] data;
    } udv_rd_rsp_s;

    typedef enum logic [1:0] {
        UDV_ST_WAIT = 2'b00,
        UDV_ST_SETTLE = 2'b01,
        UDV_ST_LOCK = 2'b10
    } udv_cap_e;

endpackage : udv_pkg

//--- udv_strap_cap.sv
// synchronises and freezes the protocol support straps
`include "udv_params.svh"

module udv_strap_cap (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire udv_pkg::udv_strap_s strap_i,
    output udv_pkg::udv_strap_s strap_o,
    output logic locked_o
);

    udv_pkg::udv_strap_s sync1;
    udv_pkg::udv_strap_s sync2;
    udv_pkg::udv_strap_s held;
    udv_pkg::udv_strap_s next_held;
    udv_pkg::udv_cap_e state;
    udv_pkg::udv_cap_e next_state;
    logic [1:0] cnt;
    logic [1:0] next_cnt;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= strap_i;
            sync2 <= sync1;
        end
    end

    // wait until the synchroniser holds post-reset pin levels, then freeze
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_held = held;
        case (state)
            udv_pkg::UDV_ST_WAIT: begin
                next_cnt = 2'h0;
                next_state = udv_pkg::UDV_ST_SETTLE;
            end
            udv_pkg::UDV_ST_SETTLE: begin
                next_cnt = cnt + 2'h1;
                if (cnt == `UDV_SETTLE_CYC - 2'h1) begin
                    next_held = sync2;
                    next_state = udv_pkg::UDV_ST_LOCK;
                end
            end
            udv_pkg::UDV_ST_LOCK: begin
                next_state = udv_pkg::UDV_ST_LOCK;
            end
            default: begin
                next_state = udv_pkg::UDV_ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= udv_pkg::UDV_ST_WAIT;
            cnt <= 2'h0;
            held <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            held <= next_held;
        end
    end

    assign strap_o = held;
    assign locked_o = (state == udv_pkg::UDV_ST_LOCK);

    localparam int lock_max = `UDV_LOCK_MAX;

    a_lock_bounded: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        !locked_o |-> ##[1:lock_max] locked_o)
        else $error("straps not frozen in time");

    a_held_frozen: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        locked_o |=> locked_o && $stable(strap_o))
        else $error("frozen straps changed");

endmodule : udv_strap_cap

//--- udv_host_model.sv
// host side model that reads udid bytes from the target
module udv_host_model (
    input wire logic core_clk_i,
    input wire udv_pkg::udv_rd_rsp_s rd_rsp_i,
    output udv_pkg::udv_rd_req_s rd_req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] idx_list [0:15];
    udv_pkg::udv_rd_rsp_s rsp_list [0:16];

    initial rd_req_o = '0;

    // request held high, index moved each cycle; rsp_list[n] is the idle cycle
    // subsystem ids read as defining body plus equivalence level, not among these bytes
    task automatic run_reads(input int n);
        for (int i = 0; i <= n; i++) begin
            @(negedge core_clk_i);
            if (i > 0) begin
                rsp_list[i - 1] = rd_rsp_i;
            end
            rd_req_o.req = (i < n);
            // released index no longer shows the last value
            rd_req_o.idx = (i < n) ? idx_list[i] : ~rd_req_o.idx;
        end
        @(negedge core_clk_i);
        rsp_list[n] = rd_rsp_i;
    endtask : run_reads
endmodule : udv_host_model

//--- testbench.sv
// self-checking bench for the udid version and interface fields
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [2:0] SIL = 3'h5;

    logic core_clk_i;
    logic rstn_i;
    logic valid;
    udv_pkg::udv_strap_s strap;
    udv_pkg::udv_rd_req_s rd_req;
    udv_pkg::udv_rd_rsp_s rd_rsp;
    udv_pkg::udv_ver_s ver;
    udv_pkg::udv_if_s ifw;
    int n_errors = 0;
    int compares = 0;

    udv_id_fields #(.SIL_REV(SIL)) dut_u (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .strap_ipmi_i(strap.ipmi),
        .strap_asf_i(strap.asf),
        .strap_oem_i(strap.oem),
        .rd_req_i(rd_req),
        .version_revision_byte_o(ver),
        .interface_capability_word_o(ifw),
        .fields_valid_o(valid),
        .rd_rsp_o(rd_rsp)
    );

    udv_host_model host_u (
        .core_clk_i(core_clk_i),
        .rd_rsp_i(rd_rsp),
        .rd_req_o(rd_req)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] exp_ver();
        return {2'b00, 3'b001, SIL};
    endfunction : exp_ver

    function automatic logic [15:0] exp_if(input udv_pkg::udv_strap_s s);
        return {9'h000, s.ipmi, s.asf, s.oem, 4'b0100};
    endfunction : exp_if

    function automatic logic [15:0] exp_rsp(input logic [3:0] idx, input udv_pkg::udv_strap_s s);
        logic [15:0] w;
        w = exp_if(s);
        case (idx)
            4'h1: return {8'h03, exp_ver()};
            4'h6: return {8'h03, w[15:8]};
            4'h7: return {8'h03, w[7:0]};
            default: return 16'h0200;
        endcase
    endfunction : exp_rsp

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // one reset, freeze and read sequence with the given straps
    task automatic session(input udv_pkg::udv_strap_s s);
        int n;
        logic [15:0] seen;
        n = 16;
        @(negedge core_clk_i);
        rstn_i = 1'b0;
        strap = s;
        repeat (6) @(negedge core_clk_i);
        check("version in reset", {8'h00, ver}, {8'h00, exp_ver()});
        check("interface in reset", ifw, 16'h0004);
        check("valid in reset", {15'h0000, valid}, 16'h0000);
        rstn_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        check("valid before freeze", {15'h0000, valid}, 16'h0000);
        @(negedge core_clk_i);
        check("valid after freeze", {15'h0000, valid}, 16'h0001);
        check("interface", ifw, exp_if(s));
        // late strap change must be ignored
        strap = udv_pkg::udv_strap_s'(~s);
        for (int i = 0; i < n; i++) begin
            host_u.idx_list[i] = (i == 0) ? 4'h1 : (i == 1) ? 4'h6 : (i == 2) ? 4'h7 :
                4'($urandom_range(15, 0));
        end
        host_u.run_reads(n);
        for (int i = 0; i < n; i++) begin
            seen = {6'h00, host_u.rsp_list[i]};
            check("read response", seen, exp_rsp(host_u.idx_list[i], s));
        end
        check("idle response", {6'h00, host_u.rsp_list[n]}, 16'h0000);
        check("interface held", ifw, exp_if(s));
        check("version held", {8'h00, ver}, {8'h00, exp_ver()});
    endtask : session

    initial begin
        rstn_i = 1'b0;
        strap = '0;
        void'($urandom(32'hca2c));
        for (int c = 0; c < 8; c++) begin
            session(udv_pkg::udv_strap_s'(3'(c)));
        end
        repeat (4) begin
            session(udv_pkg::udv_strap_s'(3'($urandom_range(7, 0))));
        end
        report_and_stop();
    end

    // about 29 cycles a session; far more than twelve sessions need
    initial begin
        #50000;
        n_errors++;
        report_and_stop();
    end
endmodule : testbench
